// *** bench/low_power_timer_asserts.sv ***
`timescale 1ns/1ns
module low_power_timer_asserts
    import low_power_timer_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [15:0] count,
    input wire logic        compare_wakeup,
    input wire logic        reload_event
);
    logic [15:0] rel_sh;
    logic [15:0] cmp_sh;
    logic        en_sh;
    logic        gt_sh;
    logic        mr_sh;
    logic        run_sh;

    assign run_sh = en_sh & gt_sh;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rel_sh <= RELOAD_RESET;
            cmp_sh <= 16'h0;
            en_sh  <= 1'b0;
            gt_sh  <= 1'b0;
            mr_sh  <= 1'b0;
        end else if (wr) begin
            if (addr == RELOAD_ADDR) rel_sh <= wdata[15:0];
            if (addr == CMP_ADDR) cmp_sh <= wdata[15:0];
            if (addr == CTRL_ADDR) en_sh <= wdata[ENABLE_BIT];
            if (addr == RCC_ADDR) gt_sh <= wdata[MOD_GATE_BIT];
            if (addr == RCC_ADDR) mr_sh <= wdata[MOD_RST_BIT];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read answer");
    AST_RD_COUNT: assert property (rd && addr == COUNT_ADDR |=> rdata == $past(count))
        else $error("count read does not match counter");
    AST_UNMAPPED: assert property (rd && addr > RCC_ADDR |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_COUNT_UP: assert property (count != $past(count) |-> count == $past(count) + 16'h1 || count == 16'h0)
        else $error("counter moved other than up by one or to zero");
    AST_WRAP_AT_RELOAD: assert property (reload_event |-> $past(count) == rel_sh || $past(count, 2) == rel_sh)
        else $error("reload event without reaching reload value");
    AST_EVENT_PULSE: assert property (reload_event |=> !reload_event)
        else $error("reload event longer than one cycle");
    AST_WAKE_MATCH: assert property (compare_wakeup |-> $past(count) == cmp_sh || $past(count, 2) == cmp_sh)
        else $error("wakeup without compare match");
    AST_HOLD_STOPPED: assert property (!run_sh && !$past(run_sh, 4) |=> count == $past(count) || count == 16'h0)
        else $error("counter moved while disabled or gated");
    AST_MODULE_RESET: assert property (mr_sh |-> ##[0:2] count == 16'h0)
        else $error("counter not cleared under module reset");

    COV_WRAP: cover property (reload_event);
    COV_WAKE: cover property (compare_wakeup);
    COV_COUNT_READ: cover property (rd && addr == COUNT_ADDR);
endmodule

bind low_power_timer low_power_timer_asserts u_low_power_timer_asserts (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .count(count), .compare_wakeup(compare_wakeup), .reload_event(reload_event)
);

// *** bench/pulse_source_model.sv ***
`timescale 1ns/1ns
module pulse_source_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] fire_src,
    input  wire logic       fire,
    output logic      [3:0] ticks,
    output logic            ext_in,
    output logic      [2:0] trig
);
    int         cyc;
    logic [2:0] hold;

    // Coprime tick rates make each kernel choice show its own period
    assign ticks = {cyc % 7 == 0, cyc % 5 == 0, cyc % 3 == 0, cyc % 2 == 0};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc    <= 0;
            hold   <= 3'h0;
            ext_in <= 1'b0;
            trig   <= 3'h0;
        end else begin
            cyc <= cyc + 1;
            // Eight-cycle period, four times slower than the bus tick
            if (cyc % 4 == 0) ext_in <= ~ext_in;
            if (fire) begin
                trig[fire_src] <= 1'b1;
                hold           <= 3'h6;
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end else begin
                trig <= 3'h0;
            end
        end
    end
endmodule

// *** bench/tb_low_power_timer.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb_low_power_timer;
    import low_power_timer_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] count;
    logic        compare_wakeup;
    logic        reload_event;
    logic [3:0]  ticks;
    logic [2:0]  trig;
    logic        ext_in;
    logic        fire = 1'b0;
    logic [1:0]  fire_src = 2'h0;
    logic [31:0] cf;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          n;
    int          t1;
    int          wk;
    int          kp[4] = '{2, 3, 5, 7};

    low_power_timer u_low_power_timer (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .bus_clock_tick(ticks[0]), .fast_osc_tick(ticks[1]), .slow_crystal_tick(ticks[2]),
        .slow_osc_tick(ticks[3]), .external_input_one(ext_in), .external_trigger_pin(trig[0]),
        .clock_alarm(trig[1]), .tamper_input(trig[2]), .count(count),
        .compare_wakeup(compare_wakeup), .reload_event(reload_event)
    );
    pulse_source_model u_pulse_source_model (
        .clk(clk), .rst(rst), .fire_src(fire_src), .fire(fire),
        .ticks(ticks), .ext_in(ext_in), .trig(trig)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic give_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e)
        @(posedge clk);
    endtask

    // Returns cycles until a wrap, or lim when none came
    task automatic wait_ev(input int lim, input bit must, output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
            wk += int'(compare_wakeup === 1'b1);
        end while (reload_event !== 1'b1 && c < lim);
        if (must && c >= lim) begin
            error_cnt++;
            give_verdict();
        end
        @(posedge clk);
    endtask

    // Start aligned to a bus tick so repeated runs time alike
    task automatic arm(input logic [31:0] cfg, input logic [31:0] cv);
        wreg(CTRL_ADDR, 32'h0);
        wreg(CFG_ADDR, cfg);
        wreg(CTRL_ADDR, 32'h1);
        @(negedge clk);
        if (ticks[0] !== 1'b1) @(negedge clk);
        @(posedge clk);
        wreg(CTRL_ADDR, cv);
    endtask

    task automatic meas(input logic [31:0] cfg, input int exp);
        arm(cfg, 32'h5);
        wait_ev(9000, 1, n);
        wk = 0;
        wait_ev(9000, 1, n);
        `CHK(n, exp)
        `CHK(wk, 1)
    endtask

    task automatic fire_at(input logic [1:0] s);
        fire_src <= s;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
    endtask

    task automatic trg(input logic [31:0] cfg, input logic [1:0] s, input bit mid, output int t);
        arm(cfg, 32'h3);
        fire_at(s);
        wait_ev(20, 0, t);
        if (mid) fire_at(s);
        else repeat (2) @(posedge clk);
        wait_ev(2000, 1, t);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(RELOAD_ADDR, 32'h0000ffff);
        rchk(CFG_ADDR, 32'h0);
        rchk(8'h1c, 32'h0);
        wreg(RCC_ADDR, 32'h2);
        wreg(RELOAD_ADDR, 32'h9);
        wreg(CMP_ADDR, 32'h5);
        rchk(RELOAD_ADDR, 32'h9);
        for (int k = 0; k < 4; k++) meas(32'(k) << KCLK_SEL_LSB, 10 * kp[k]);
        for (int p = 0; p < 8; p++) meas(32'(p) << PRESCALE_LSB, 20 << p);
        // Count mode set on the inverted run must make no difference
        for (int p = 0; p < 2; p++) meas(32'(p * 2 + 1) | (32'(p) << COUNT_MODE_BIT), 80);
        meas(32'h1 << COUNT_MODE_BIT, 80);
        // Four-cycle input levels give two kernel samples: enough for two, never three
        meas(32'h1 | (32'h2 << CLK_FILT_LSB), 80);
        arm(32'h1 | (32'h3 << CLK_FILT_LSB), 32'h5);
        wait_ev(300, 0, n);
        `CHK(n, 300)
        arm(32'h5, 32'h5);
        wait_ev(300, 0, n);
        `CHK(n, 300)
        wreg(CTRL_ADDR, 32'h0);
        wreg(CFG_ADDR, 32'h0);
        wreg(CTRL_ADDR, 32'h4);
        wreg(CTRL_ADDR, 32'h1);
        wait_ev(300, 0, n);
        `CHK(n, 300)
        wreg(RELOAD_ADDR, 32'd40);
        for (int i = 0; i < 3; i++) begin
            cf = (32'(i + 1) << TRG_EDGE_LSB) | (32'(i) << TRG_SRC_LSB);
            trg(cf, 2'(i), 0, t1);
            wait_ev(300, 0, n);
            `CHK(n, 300)
            trg(cf, 2'(i), 1, n);
            `CHK(n, t1)
            fire_at(2'(i));
            wait_ev(2000, 0, n);
            `CHK(n < 2000, 1'b1)
        end
        trg((32'h1 << TRG_EDGE_LSB) | (32'h1 << WAVE_SET_BIT), 2'h0, 0, n);
        fire_at(2'h0);
        wait_ev(400, 0, n);
        `CHK(n, 400)
        arm((32'h1 << TRG_EDGE_LSB) | (32'h1 << TRG_SRC_LSB) | (32'h1 << TIMEOUT_BIT), 32'h5);
        wait_ev(200, 0, n);
        `CHK(n, 200)
        wk = 0;
        repeat (5) begin
            fire_at(2'h1);
            wait_ev(60, 0, n);
            `CHK(n, 60)
        end
        // Each restarted count passes the compare value once
        `CHK(wk, 5)
        wait_ev(200, 1, n);
        arm(32'h0, 32'h5);
        wait_ev(200, 1, n);
        wreg(CTRL_ADDR, 32'h3);
        wait_ev(200, 1, n);
        wait_ev(300, 0, n);
        `CHK(n, 300)
        wreg(CTRL_ADDR, 32'h3);
        wreg(CTRL_ADDR, 32'h5);
        wait_ev(200, 1, n);
        wait_ev(200, 1, n);
        arm(32'h0, 32'h5);
        wait_ev(200, 1, n);
        wreg(RCC_ADDR, 32'h0);
        wait_ev(300, 0, n);
        `CHK(n, 300)
        // Count must be running when the module reset lands
        wreg(RCC_ADDR, 32'h2);
        wreg(CTRL_ADDR, 32'h5);
        wait_ev(200, 1, n);
        wreg(RCC_ADDR, 32'h3);
        rchk(COUNT_ADDR, 32'h0);
        wreg(RCC_ADDR, 32'h2);
        give_verdict();
    end
endmodule

// *** common/low_power_timer_pkg.sv ***
package low_power_timer_pkg;

    // ------------------------------------------------------------
    // Configuration register layout
    // ------------------------------------------------------------
    localparam int EXT_POL_LSB      = 1;
    localparam int CLK_FILT_LSB     = 3;
    localparam int TRG_FILT_LSB     = 6;
    localparam int PRESCALE_LSB     = 9;
    localparam int TRG_SRC_LSB      = 13;
    localparam int TRG_EDGE_LSB     = 17;
    localparam int WAVE_SET_BIT     = 20;
    localparam int TIMEOUT_BIT      = 19;
    localparam int CLK_SEL_BIT      = 0;
    localparam int COUNT_MODE_BIT   = 23;
    localparam int KCLK_SEL_LSB     = 25;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_ADDR    = 8'h00;
    localparam logic [7:0] CTRL_ADDR   = 8'h04;
    localparam logic [7:0] CMP_ADDR    = 8'h08;
    localparam logic [7:0] RELOAD_ADDR = 8'h0c;
    localparam logic [7:0] COUNT_ADDR  = 8'h10;
    localparam logic [7:0] STAT_ADDR   = 8'h14;
    localparam logic [7:0] RCC_ADDR    = 8'h18;

    // Control register bits
    localparam int ENABLE_BIT   = 0;
    localparam int SNG_BIT      = 1;
    localparam int CNT_BIT      = 2;
    // Clock-controller bits
    localparam int MOD_RST_BIT  = 0;
    localparam int MOD_GATE_BIT = 1;

    localparam logic [15:0] RELOAD_RESET = 16'hffff;
    localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
    localparam int          ENABLE_DELAY = 2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ARMED  = 2'b01,
        ST_RUN    = 2'b10,
        ST_LOCKED = 2'b11
    } run_state_e;

endpackage

// *** rtl/low_power_timer.sv ***
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ns
module low_power_timer
    import low_power_timer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        bus_clock_tick,
    input  wire logic        fast_osc_tick,
    input  wire logic        slow_crystal_tick,
    input  wire logic        slow_osc_tick,
    input  wire logic        external_input_one,
    input  wire logic        external_trigger_pin,
    input  wire logic        clock_alarm,
    input  wire logic        tamper_input,
    output logic      [15:0] count,
    output logic             compare_wakeup,
    output logic             reload_event
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Filter: accept new level after n equal samples (n=0 bypass)
    function automatic logic [3:0] filt_next_cnt(input logic [3:0] c, input logic raw,
                                                 input logic lvl);
        return (raw == lvl) ? 4'h0 : c + 4'h1;
    endfunction

    function automatic logic edge_hit(input logic [1:0] mode, input logic now, input logic prev);
        case (mode)
            2'b01:   return now & ~prev;
            2'b10:   return ~now & prev;
            2'b11:   return now ^ prev;
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] cfg, next_cfg;
    logic [2:0]  ctrl, next_ctrl;
    logic [15:0] cmp, next_cmp;
    logic [15:0] reload, next_reload;
    logic [1:0]  rcc, next_rcc;
    logic [31:0] next_rdata;
    logic        sng_req, cnt_req;

    always_comb begin
        next_cfg    = cfg;
        next_ctrl   = {1'b0, 1'b0, ctrl[ENABLE_BIT]};
        next_cmp    = cmp;
        next_reload = reload;
        next_rcc    = rcc;
        sng_req     = 1'b0;
        cnt_req     = 1'b0;
        if (wr) begin
            unique case (addr)
                CFG_ADDR:    next_cfg = wdata;
                CTRL_ADDR: begin
                    next_ctrl[ENABLE_BIT] = wdata[ENABLE_BIT];
                    sng_req = wdata[SNG_BIT] & ctrl[ENABLE_BIT];
                    cnt_req = wdata[CNT_BIT] & ctrl[ENABLE_BIT];
                end
                CMP_ADDR:    next_cmp = wdata[15:0];
                RELOAD_ADDR: next_reload = wdata[15:0];
                RCC_ADDR:    next_rcc = wdata[1:0];
                default:     next_cfg = cfg;
            endcase
        end
        next_rdata = 32'h0000_0000;
        if (rd) begin
            unique case (addr)
                CFG_ADDR:    next_rdata = cfg;
                CTRL_ADDR:   next_rdata = {29'h0, ctrl};
                CMP_ADDR:    next_rdata = {16'h0, cmp};
                RELOAD_ADDR: next_rdata = {16'h0, reload};
                COUNT_ADDR:  next_rdata = {16'h0, count};
                STAT_ADDR:   next_rdata = {30'h0, reload_event, compare_wakeup};
                RCC_ADDR:    next_rdata = {30'h0, rcc};
                default:     next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg    <= CFG_RESET;
            ctrl   <= 3'h0;
            cmp    <= 16'h0000;
            reload <= RELOAD_RESET;
            rcc    <= 2'h0;
            rdata  <= 32'h0000_0000;
        end else begin
            cfg    <= next_cfg;
            ctrl   <= next_ctrl;
            cmp    <= next_cmp;
            reload <= next_reload;
            rcc    <= next_rcc;
            rdata  <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Clock selection and filters
    // ------------------------------------------------------------
    logic       active;
    logic       kernel_tick;
    logic       ext_raw, trg_raw;
    logic       ext_lvl, trg_lvl, next_ext_lvl, next_trg_lvl;
    logic [3:0] ext_fc, trg_fc, next_ext_fc, next_trg_fc;
    logic       ext_prev, trg_prev;
    logic [1:0] ext_pol;
    logic       ext_tick, trg_hit, count_tick;
    logic [6:0] pre, next_pre;
    logic [1:0] en_dly, next_en_dly;
    logic       pre_tick;

    // Held in reset by module bit or gate low; the filters keep sampling either way
    assign active = ~rcc[MOD_RST_BIT] & rcc[MOD_GATE_BIT] & ctrl[ENABLE_BIT];

    always_comb begin
        unique case (cfg[KCLK_SEL_LSB +: 2])
            2'b00: kernel_tick = bus_clock_tick;
            2'b01: kernel_tick = fast_osc_tick;
            2'b10: kernel_tick = slow_crystal_tick;
            2'b11: kernel_tick = slow_osc_tick;
        endcase
        ext_pol = cfg[EXT_POL_LSB +: 2];
        ext_raw = (ext_pol == 2'b01) ? ~external_input_one : external_input_one;
        unique case (cfg[TRG_SRC_LSB +: 2])
            2'b00:   trg_raw = external_trigger_pin;
            2'b01:   trg_raw = clock_alarm;
            2'b10:   trg_raw = tamper_input;
            default: trg_raw = 1'b0;
        endcase
        // Filters sample on kernel ticks; zero sensitivity passes through
        next_ext_lvl = ext_lvl;
        next_ext_fc  = ext_fc;
        next_trg_lvl = trg_lvl;
        next_trg_fc  = trg_fc;
        if (cfg[CLK_FILT_LSB +: 3] == 3'h0) begin
            next_ext_lvl = ext_raw;
            next_ext_fc  = 4'h0;
        end else if (kernel_tick) begin
            next_ext_fc = filt_next_cnt(ext_fc, ext_raw, ext_lvl);
            if (next_ext_fc >= {1'b0, cfg[CLK_FILT_LSB +: 3]}) begin
                next_ext_lvl = ext_raw;
                next_ext_fc  = 4'h0;
            end
        end
        if (cfg[TRG_FILT_LSB +: 3] == 3'h0) begin
            next_trg_lvl = trg_raw;
            next_trg_fc  = 4'h0;
        end else if (kernel_tick) begin
            next_trg_fc = filt_next_cnt(trg_fc, trg_raw, trg_lvl);
            if (next_trg_fc >= {1'b0, cfg[TRG_FILT_LSB +: 3]}) begin
                next_trg_lvl = trg_raw;
                next_trg_fc  = 4'h0;
            end
        end
        // External counting edge: rising of selected-polarity signal for polarity 00 or 01; none for 1x
        ext_tick = (ext_pol[1] == 1'b0) & ext_lvl & ~ext_prev;
        trg_hit  = edge_hit(cfg[TRG_EDGE_LSB +: 2], trg_lvl, trg_prev) & active;
        // Source of counting clock
        if (cfg[CLK_SEL_BIT]) begin
            count_tick = ext_tick;
        end else if (cfg[COUNT_MODE_BIT]) begin
            count_tick = ext_tick;
        end else begin
            count_tick = kernel_tick;
        end
        // Enable delay counted in counting-clock cycles
        next_en_dly = en_dly;
        if (!active) begin
            next_en_dly = 2'h0;
        end else if (count_tick && en_dly != 2'(ENABLE_DELAY)) begin
            next_en_dly = en_dly + 2'h1;
        end
        // Prescaler: 2^n division by counting low bits
        next_pre = pre;
        pre_tick = 1'b0;
        if (!active) begin
            next_pre = 7'h00;
        end else if (count_tick && en_dly == 2'(ENABLE_DELAY)) begin
            next_pre = pre + 7'h01;
            pre_tick = ((pre & 7'((8'h01 << cfg[PRESCALE_LSB +: 3]) - 8'h01))
                        == 7'((8'h01 << cfg[PRESCALE_LSB +: 3]) - 8'h01));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_lvl  <= 1'b0;
            trg_lvl  <= 1'b0;
            ext_fc   <= 4'h0;
            trg_fc   <= 4'h0;
            ext_prev <= 1'b0;
            trg_prev <= 1'b0;
            pre      <= 7'h00;
            en_dly   <= 2'h0;
        end else begin
            ext_lvl  <= next_ext_lvl;
            trg_lvl  <= next_trg_lvl;
            ext_fc   <= next_ext_fc;
            trg_fc   <= next_trg_fc;
            ext_prev <= ext_lvl;
            trg_prev <= trg_lvl;
            pre      <= next_pre;
            en_dly   <= next_en_dly;
        end
    end

    // ------------------------------------------------------------
    // Run control and counter
    // ------------------------------------------------------------
    run_state_e  state, next_state;
    logic        continuous, next_continuous;
    logic [15:0] next_count;
    logic        next_cmp_evt, next_rl_evt;
    logic        sw_start, at_reload;

    always_comb begin
        next_state      = state;
        next_continuous = continuous;
        next_count      = count;
        next_cmp_evt    = 1'b0;
        next_rl_evt     = 1'b0;
        sw_start        = (cfg[TRG_EDGE_LSB +: 2] == 2'b00);
        at_reload       = (count == reload);
        if (!active) begin
            next_state = ST_IDLE;
            next_count = 16'h0000;
        end else begin
            if (sng_req) begin
                next_continuous = 1'b0;
            end
            if (cnt_req) begin
                next_continuous = 1'b1;
            end
            unique case (state)
                ST_IDLE, ST_ARMED: begin
                    if (sng_req || cnt_req) begin
                        next_state = (sw_start) ? ST_RUN : ST_ARMED;
                    end else if (state == ST_ARMED && trg_hit) begin
                        next_state = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (cfg[TIMEOUT_BIT] && trg_hit) begin
                        next_count = 16'h0000;
                    end else if (pre_tick) begin
                        if (at_reload) begin
                            next_rl_evt = 1'b1;
                            next_count  = 16'h0000;
                            if (!continuous) begin
                                // Wave-set or software start locks after the single shot; else rearm
                                next_state = (cfg[WAVE_SET_BIT] || sw_start) ? ST_LOCKED
                                           : ST_ARMED;
                            end
                        end else begin
                            next_count = count + 16'h0001;
                        end
                    end
                    // Triggers during a count are otherwise ignored
                    if (state == ST_RUN && sng_req && !sw_start && !cfg[TIMEOUT_BIT]) begin
                        next_state = ST_RUN;
                    end
                end
                ST_LOCKED: begin
                    if (sng_req && sw_start && !cfg[WAVE_SET_BIT]) begin
                        next_state = ST_RUN;
                    end else if (cnt_req) begin
                        next_state = sw_start ? ST_RUN : ST_ARMED;
                    end
                end
            endcase
            if (pre_tick && state == ST_RUN && count == cmp) begin
                next_cmp_evt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state          <= ST_IDLE;
            continuous     <= 1'b0;
            count          <= 16'h0000;
            compare_wakeup <= 1'b0;
            reload_event   <= 1'b0;
        end else begin
            state          <= next_state;
            continuous     <= next_continuous;
            count          <= next_count;
            compare_wakeup <= next_cmp_evt;
            reload_event   <= next_rl_evt;
        end
    end

endmodule
